// [common/lcsb_cob_if.sv]
// Interface: castout buffer load and drain signals
`timescale 1ns/1ps
interface lcsb_cob_if;
  logic                           load;
  logic [lcsb_pkg::ADDR_W-1:0]    load_addr;
  logic [lcsb_pkg::LINE_W-1:0]    load_line;
  logic                           full;
  logic [lcsb_pkg::ADDR_W-1:0]    addr;
  logic [1:0]                     beat_sel;
  logic [lcsb_pkg::BEAT_W-1:0]    beat;
  logic                           drain_done;
  modport ctrl (output load, load_addr, load_line, beat_sel, drain_done,
                input full, addr, beat);
  modport buf_side (input load, load_addr, load_line, beat_sel, drain_done,
                    output full, addr, beat);
endinterface

// [common/lcsb_pkg.sv]
// Package: bus-side constants and states of the secondary cache control
package lcsb_pkg;
  localparam int unsigned BEATS      = 4;
  localparam logic [1:0]  LAST_BEAT  = 2'h3;
  localparam int unsigned BR_DELAY   = 2;
  localparam int unsigned CO_TA_MIN  = 2;
  localparam int unsigned LINE_W     = 256;
  localparam int unsigned BEAT_W     = 64;
  localparam int unsigned ADDR_W     = 32;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_HIT     = 3'h1,
    ST_MISS    = 3'h2,
    ST_SNP_RTY = 3'h3,
    ST_SNP_BRW = 3'h4,
    ST_WAIT_BG = 3'h5,
    ST_CO_ADDR = 3'h6,
    ST_CO_DATA = 3'h7
  } lcsb_state_e;
endpackage

// [rtl/lcsb_beat_cnt.sv]
// Beat counter for one four-beat data tenure
`timescale 1ns/1ps
module lcsb_beat_cnt (
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  input  wire logic       CE,
  input  wire logic       clr,
  input  wire logic       step,
  output logic [1:0]      count,
  output logic            last
);
  logic [1:0] cnt_reg, cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (clr)
      cnt_next = 2'h0;
    else if (step)
      cnt_next = cnt_reg + 2'h1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      cnt_reg <= 2'h0;
    else if (CE)
      cnt_reg <= cnt_next;
  end

  assign count = cnt_reg;
  assign last  = step && (cnt_reg == lcsb_pkg::LAST_BEAT);
endmodule

// [rtl/lcsb_cob.sv]
// Castout buffer: one dirty line held for write-back
`timescale 1ns/1ps
module lcsb_cob (
  input  wire logic   REF_CLK,
  input  wire logic   RESETN,
  input  wire logic   CE,
  lcsb_cob_if.buf_side cob
);
  logic                        full_reg, full_next;
  logic [lcsb_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [lcsb_pkg::LINE_W-1:0] line_reg, line_next;

  always_comb
  begin
    full_next = full_reg;
    addr_next = addr_reg;
    line_next = line_reg;
    if (cob.drain_done)
      full_next = 1'b0;
    if (cob.load)
    begin
      full_next = 1'b1;
      addr_next = cob.load_addr;
      line_next = cob.load_line;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      full_reg <= 1'b0;
      addr_reg <= '0;
      line_reg <= '0;
    end
    else if (CE)
    begin
      full_reg <= full_next;
      addr_reg <= addr_next;
      line_reg <= line_next;
    end
  end

  assign cob.full = full_reg;
  assign cob.addr = addr_reg;
  assign cob.beat = line_reg[cob.beat_sel*lcsb_pkg::BEAT_W +:
                             lcsb_pkg::BEAT_W];
endmodule

// [rtl/lcsb_top.sv]
// Bus-side hit, miss, castout and snoop control of the secondary cache
`timescale 1ns/1ps
module lcsb_top (
  input  wire logic                          REF_CLK,
  input  wire logic                          RESETN,
  input  wire logic                          CE,
  input  wire logic                          TRANSFER_START,
  input  wire logic                          WRITE_THROUGH_ATTR,
  input  wire logic                          IS_WRITE,
  input  wire logic                          SNOOP,
  input  wire logic [lcsb_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic                          LOOKUP_HIT,
  input  wire logic                          LOOKUP_DIRTY,
  input  wire logic [lcsb_pkg::ADDR_W-1:0]   VICTIM_ADDR,
  input  wire logic [lcsb_pkg::LINE_W-1:0]   VICTIM_LINE,
  input  wire logic                          ADDRESS_ACK_IN,
  input  wire logic                          TRANSFER_ACK_IN,
  input  wire logic                          PROCESSOR_BUS_REQUEST,
  input  wire logic                          PROCESSOR_DATA_GRANT,
  input  wire logic                          CACHE_BUS_GRANT,
  input  wire logic [lcsb_pkg::BEAT_W-1:0]   HIT_DATA,
  output logic                               HIT_CLAIM,
  output logic                               ADDRESS_ACK_OUT,
  output logic                               ADDRESS_ACK_OE,
  output logic                               ADDRESS_RETRY_OUT,
  output logic                               ADDRESS_RETRY_OE,
  output logic                               TRANSFER_ACK_OUT,
  output logic                               TRANSFER_ACK_OE,
  output logic                               CACHE_BUS_REQUEST,
  output logic                               CO_TRANSFER_START,
  output logic [lcsb_pkg::ADDR_W-1:0]        CO_ADDR,
  output logic                               DATA_OE,
  output logic [lcsb_pkg::BEAT_W-1:0]        DATA_OUT,
  output logic                               LINE_WT,
  output logic                               LINE_UPDATE,
  output logic                               LINE_INVALIDATE,
  output logic                               ARRAY_FILL
);
  lcsb_cob_if cob ();

  lcsb_pkg::lcsb_state_e       st_reg, st_next;
  logic                        wr_reg, wr_next;
  logic [1:0]                  dly_reg, dly_next;
  logic                        address_ack_seen_reg, address_ack_seen_next;
  logic                        claim_reg, claim_next;
  logic                        address_ack_reg, address_ack_next;
  logic                        ta_reg, ta_next;
  logic                        rty_reg, rty_next;
  logic                        br_reg, br_next;
  logic                        ts_reg, ts_next;
  logic                        co_pend_reg, co_pend_next;
  logic                        defer_reg, defer_next;
  logic                        wt_reg, wt_next;
  logic [lcsb_pkg::BEAT_W-1:0] dout_reg, dout_next;
  logic                        dout_oe_reg, dout_oe_next;
  logic [lcsb_pkg::ADDR_W-1:0] snp_addr_reg, snp_addr_next;
  logic                        upd_reg, upd_next;
  logic                        inv_reg, inv_next;
  logic                        fill_reg, fill_next;
  logic                        beat_step, beat_clr, beat_last;
  logic [1:0]                  beat_cnt;
  logic                        hit_ta;

  lcsb_cob u_cob (
    .REF_CLK (REF_CLK),
    .RESETN  (RESETN),
    .CE      (CE),
    .cob     (cob)
  );

  lcsb_beat_cnt u_beat (
    .REF_CLK (REF_CLK),
    .RESETN  (RESETN),
    .CE      (CE),
    .clr     (beat_clr),
    .step    (beat_step),
    .count   (beat_cnt),
    .last    (beat_last)
  );

  // Beat advance: acks standing on the bus, so a parked first ack counts
  assign hit_ta    = (st_reg == lcsb_pkg::ST_HIT) && PROCESSOR_DATA_GRANT;
  assign beat_step = ((st_reg == lcsb_pkg::ST_HIT) && ta_reg)
                   || (((st_reg == lcsb_pkg::ST_MISS)
                        || (st_reg == lcsb_pkg::ST_CO_DATA))
                       && TRANSFER_ACK_IN);
  assign beat_clr  = (st_reg == lcsb_pkg::ST_IDLE);

  // Stage the next beat so data stands in the cycle that is acked
  assign cob.beat_sel   = beat_step ? beat_cnt + 2'h1 : beat_cnt;
  assign cob.drain_done = (st_reg == lcsb_pkg::ST_CO_DATA) && beat_last;
  assign cob.load       = ((st_reg == lcsb_pkg::ST_MISS) && beat_last
                           && dly_reg != 2'h0)
                          || ((st_reg == lcsb_pkg::ST_SNP_BRW)
                              && !PROCESSOR_BUS_REQUEST);
  assign cob.load_addr  = (st_reg == lcsb_pkg::ST_SNP_BRW) ? snp_addr_reg
                                                           : VICTIM_ADDR;
  assign cob.load_line  = VICTIM_LINE;

  always_comb
  begin
    st_next        = st_reg;
    wr_next        = wr_reg;
    dly_next       = dly_reg;
    address_ack_seen_next = address_ack_seen_reg;
    claim_next     = 1'b0;
    address_ack_next      = 1'b0;
    ta_next        = 1'b0;
    rty_next       = 1'b0;
    br_next        = br_reg;
    ts_next        = 1'b0;
    co_pend_next   = co_pend_reg;
    defer_next     = defer_reg;
    wt_next        = 1'b0;
    dout_next      = dout_reg;
    dout_oe_next   = 1'b0;
    snp_addr_next  = snp_addr_reg;
    upd_next       = 1'b0;
    inv_next       = 1'b0;
    fill_next      = 1'b0;
    unique case (st_reg)
      lcsb_pkg::ST_IDLE:
      begin
        if (TRANSFER_START)
        begin
          wr_next = IS_WRITE;
          wt_next = WRITE_THROUGH_ATTR;
          if (SNOOP && LOOKUP_HIT && LOOKUP_DIRTY)
          begin
            rty_next       = 1'b1;
            br_next        = 1'b1;
            address_ack_seen_next = 1'b0;
            snp_addr_next  = ADDR;
            st_next        = lcsb_pkg::ST_SNP_RTY;
          end
          else if (!SNOOP && LOOKUP_HIT && !(IS_WRITE
                   && WRITE_THROUGH_ATTR))
          begin
            claim_next = 1'b1;
            address_ack_next  = 1'b1;
            ta_next    = PROCESSOR_DATA_GRANT;
            dout_oe_next = PROCESSOR_DATA_GRANT && !IS_WRITE;
            dout_next  = HIT_DATA;
            st_next    = lcsb_pkg::ST_HIT;
          end
          else if (!SNOOP && !LOOKUP_HIT)
          begin
            dly_next = LOOKUP_DIRTY ? 2'h1 : 2'h0;
            st_next  = lcsb_pkg::ST_MISS;
          end
        end
        else if (co_pend_reg)
        begin
          br_next = 1'b1;
          st_next = lcsb_pkg::ST_WAIT_BG;
        end
      end
      lcsb_pkg::ST_HIT:
      begin
        claim_next = address_ack_reg;
        if (hit_ta && !beat_last)
        begin
          ta_next      = 1'b1;
          dout_oe_next = !wr_reg;
          dout_next    = HIT_DATA;
        end
        if (beat_last)
          st_next = lcsb_pkg::ST_IDLE;
      end
      lcsb_pkg::ST_MISS:
      begin
        if (dly_reg == 2'h1)
        begin
          br_next  = 1'b1;
          dly_next = 2'h2;
        end
        if (beat_last)
        begin
          fill_next    = 1'b1;
          co_pend_next = dly_reg != 2'h0;
          st_next      = (dly_reg != 2'h0) ? lcsb_pkg::ST_WAIT_BG
                                           : lcsb_pkg::ST_IDLE;
          if (dly_reg != 2'h0)
            br_next = 1'b1;
        end
      end
      lcsb_pkg::ST_SNP_RTY:
      begin
        rty_next = 1'b1;
        if (address_ack_seen_reg)
        begin
          rty_next = 1'b0;
          st_next  = lcsb_pkg::ST_SNP_BRW;
        end
        else if (ADDRESS_ACK_IN)
          address_ack_seen_next = 1'b1;
      end
      lcsb_pkg::ST_SNP_BRW:
      begin
        if (PROCESSOR_BUS_REQUEST)
        begin
          br_next    = 1'b0;
          defer_next = 1'b1;
          upd_next   = !wr_reg;
          inv_next   = wr_reg;
          st_next    = lcsb_pkg::ST_IDLE;
        end
        else
        begin
          co_pend_next = 1'b1;
          st_next      = lcsb_pkg::ST_WAIT_BG;
        end
      end
      lcsb_pkg::ST_WAIT_BG:
      begin
        br_next = 1'b1;
        if (CACHE_BUS_GRANT && !defer_reg)
        begin
          br_next = 1'b0;
          ts_next = 1'b1;
          st_next = lcsb_pkg::ST_CO_ADDR;
        end
      end
      lcsb_pkg::ST_CO_ADDR:
      begin
        // first beat waits for address ack, no earlier data ack
        if (ADDRESS_ACK_IN)
        begin
          dout_oe_next = 1'b1;
          dout_next    = cob.beat;
          st_next      = lcsb_pkg::ST_CO_DATA;
        end
      end
      lcsb_pkg::ST_CO_DATA:
      begin
        dout_oe_next = 1'b1;
        dout_next    = cob.beat;
        if (beat_last)
        begin
          co_pend_next = 1'b0;
          dout_oe_next = 1'b0;
          st_next      = lcsb_pkg::ST_IDLE;
        end
      end
    endcase
    if (defer_reg && !PROCESSOR_BUS_REQUEST)
      defer_next = 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      st_reg        <= lcsb_pkg::ST_IDLE;
      wr_reg        <= 1'b0;
      dly_reg       <= 2'h0;
      address_ack_seen_reg <= 1'b0;
      claim_reg     <= 1'b0;
      address_ack_reg      <= 1'b0;
      ta_reg        <= 1'b0;
      rty_reg       <= 1'b0;
      br_reg        <= 1'b0;
      ts_reg        <= 1'b0;
      co_pend_reg   <= 1'b0;
      defer_reg     <= 1'b0;
      wt_reg        <= 1'b0;
      dout_reg      <= '0;
      dout_oe_reg   <= 1'b0;
      snp_addr_reg  <= '0;
      upd_reg       <= 1'b0;
      inv_reg       <= 1'b0;
      fill_reg      <= 1'b0;
    end
    else if (CE)
    begin
      st_reg        <= st_next;
      wr_reg        <= wr_next;
      dly_reg       <= dly_next;
      address_ack_seen_reg <= address_ack_seen_next;
      claim_reg     <= claim_next;
      address_ack_reg      <= address_ack_next;
      ta_reg        <= ta_next;
      rty_reg       <= rty_next;
      br_reg        <= br_next;
      ts_reg        <= ts_next;
      co_pend_reg   <= co_pend_next;
      defer_reg     <= defer_next;
      wt_reg        <= wt_next;
      dout_reg      <= dout_next;
      dout_oe_reg   <= dout_oe_next;
      snp_addr_reg  <= snp_addr_next;
      upd_reg       <= upd_next;
      inv_reg       <= inv_next;
      fill_reg      <= fill_next;
    end
  end

  assign HIT_CLAIM         = claim_reg;
  assign ADDRESS_ACK_OUT   = address_ack_reg;
  assign ADDRESS_ACK_OE    = address_ack_reg;
  assign ADDRESS_RETRY_OUT = rty_reg;
  assign ADDRESS_RETRY_OE  = rty_reg;
  assign TRANSFER_ACK_OUT  = ta_reg;
  assign TRANSFER_ACK_OE   = ta_reg;
  assign CACHE_BUS_REQUEST = br_reg;
  assign CO_TRANSFER_START = ts_reg;
  assign CO_ADDR           = cob.addr;
  assign DATA_OE           = dout_oe_reg;
  assign DATA_OUT          = dout_reg;
  assign LINE_WT           = wt_reg;
  assign LINE_UPDATE       = upd_reg;
  assign LINE_INVALIDATE   = inv_reg;
  assign ARRAY_FILL        = fill_reg;
endmodule

// [verif/lcsb_checker.sv]
// Assertions on the cache bus-side control ports
`timescale 1ns/1ps
module lcsb_checker (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic TRANSFER_START,
  input wire logic WRITE_THROUGH_ATTR,
  input wire logic IS_WRITE,
  input wire logic SNOOP,
  input wire logic LOOKUP_HIT,
  input wire logic LOOKUP_DIRTY,
  input wire logic ADDRESS_ACK_IN,
  input wire logic PROCESSOR_BUS_REQUEST,
  input wire logic PROCESSOR_DATA_GRANT,
  input wire logic HIT_CLAIM,
  input wire logic ADDRESS_ACK_OUT,
  input wire logic ADDRESS_ACK_OE,
  input wire logic ADDRESS_RETRY_OUT,
  input wire logic ADDRESS_RETRY_OE,
  input wire logic TRANSFER_ACK_OUT,
  input wire logic TRANSFER_ACK_OE,
  input wire logic CACHE_BUS_REQUEST,
  input wire logic CO_TRANSFER_START,
  input wire logic DATA_OE,
  input wire logic LINE_WT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  wire go    = TRANSFER_START && !SNOOP;
  wire wt_wr = go && LOOKUP_HIT && IS_WRITE && WRITE_THROUGH_ATTR;
  wire hit   = go && LOOKUP_HIT && !(IS_WRITE && WRITE_THROUGH_ATTR);
  wire miss  = go && !LOOKUP_HIT;
  wire dmiss = miss && LOOKUP_DIRTY;
  wire snp   = TRANSFER_START && SNOOP && LOOKUP_HIT && LOOKUP_DIRTY;
  wire req   = CACHE_BUS_REQUEST;
  wire rty   = ADDRESS_RETRY_OUT;
  wire address_ack  = ADDRESS_ACK_IN;
  wire pbr   = PROCESSOR_BUS_REQUEST;
  wire pdg   = PROCESSOR_DATA_GRANT;
  wire co    = CO_TRANSFER_START;
  // No claim, ack, retry, request or data drive may reach the shared bus; the castout start is not checked
  wire quiet = !(HIT_CLAIM || ADDRESS_ACK_OE || ADDRESS_RETRY_OE
    || TRANSFER_ACK_OE || req || DATA_OE);
  a_wt_mark: assert property (wt_wr |-> ##[1:3] LINE_WT)
    else $error("line not marked write-through");
  a_wt_quiet: assert property (wt_wr |=> quiet [*6])
    else $error("bus driven on write-through hit");
  a_clean_quiet: assert property (miss && !LOOKUP_DIRTY |=> quiet [*6])
    else $error("bus driven on clean miss");
  a_miss_req: assert property (dmiss |=> !req ##1 req)
    else $error("miss request not two clocks after start");
  a_miss_nodly: assert property (dmiss |=> (!rty && !TRANSFER_ACK_OE) [*4])
    else $error("miss transaction disturbed");
  a_snp_retry: assert property (snp |=> $rose(rty) && $rose(req))
    else $error("retry and request not raised together");
  a_rty_hold: assert property (rty && !address_ack && !$past(address_ack) |=> rty)
    else $error("retry dropped before address ack");
  a_rty_drop: assert property (rty && address_ack |=> rty ##1 !rty)
    else $error("retry window length wrong");
  a_br_go: assert property ($fell(rty) && !pbr |-> req)
    else $error("request lost in request window");
  a_br_defer: assert property ($fell(rty) && pbr |=> ##1 (!req && !co) [*6])
    else $error("no deferral to processor");
  a_hit_claim: assert property (hit |=> HIT_CLAIM && ADDRESS_ACK_OUT)
    else $error("hit not claimed");
  a_hit_fast: assert property (hit && pdg |=> TRANSFER_ACK_OUT)
    else $error("parked hit not acked next cycle");
  a_hit_gated: assert property (hit && !pdg |=> !TRANSFER_ACK_OUT)
    else $error("hit ack without data grant");
  c_snoop: cover property (snp);
  c_defer: cover property ($fell(rty) && pbr);
  c_castout: cover property (co);
endmodule

bind lcsb_top lcsb_checker chk (.REF_CLK, .RESETN, .TRANSFER_START,
  .WRITE_THROUGH_ATTR, .IS_WRITE, .SNOOP, .LOOKUP_HIT, .LOOKUP_DIRTY,
  .ADDRESS_ACK_IN, .PROCESSOR_BUS_REQUEST, .PROCESSOR_DATA_GRANT,
  .HIT_CLAIM, .ADDRESS_ACK_OUT, .ADDRESS_ACK_OE, .ADDRESS_RETRY_OUT,
  .ADDRESS_RETRY_OE, .TRANSFER_ACK_OUT, .TRANSFER_ACK_OE,
  .CACHE_BUS_REQUEST, .CO_TRANSFER_START, .DATA_OE, .LINE_WT);

// [verif/lcsb_mem_model.sv]
// Memory controller model: acks, cache bus grant, castout capture
`timescale 1ns/1ps
module lcsb_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mem_req,
  input  wire logic        co_ts,
  input  wire logic [3:0]  first_dly,
  input  wire logic        bus_req,
  input  wire logic        gnt_en,
  input  wire logic        data_oe,
  input  wire logic [63:0] data_in,
  output logic             address_ack = 1'b0,
  output logic             ta = 1'b0,
  output logic             gnt = 1'b0,
  output logic [255:0]     co_line
);
  int cnt = 0;
  int beat;
  int got = 4;
  always @(posedge clk)
  begin
    address_ack <= 1'b0;
    ta   <= 1'b0;
    gnt  <= rst_n && gnt_en && bus_req;
    if (!rst_n)
      cnt <= 0;
    else if (mem_req || co_ts)
    begin
      address_ack <= 1'b1;
      cnt  <= (first_dly == 4'h0) ? 1 : int'(first_dly);
      beat <= 0;
      if (co_ts)
      begin
        got     <= 0;
        co_line <= '0;
      end
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      ta   <= 1'b1;
      beat <= beat + 1;
      if (beat == 3)
        cnt <= 0;
    end
    // Beat 0 lands in the low bits
    if (ta && data_oe && got < 4)
    begin
      co_line[64*got +: 64] <= data_in;
      got <= got + 1;
    end
  end
endmodule

// [verif/test_l2_cache_miss_snoop_bus_logic.sv]
// Self-checking bench for the cache bus-side control
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module test_l2_cache_miss_snoop_bus_logic;
  logic REF_CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, TRANSFER_START = 1'b0;
  logic WRITE_THROUGH_ATTR = 1'b0, IS_WRITE = 1'b0, SNOOP = 1'b0;
  logic LOOKUP_HIT = 1'b0, LOOKUP_DIRTY = 1'b0, address_ack_tb = 1'b0;
  logic PROCESSOR_BUS_REQUEST = 1'b0, PROCESSOR_DATA_GRANT = 1'b0;
  logic gnt_en = 1'b1, mreq = 1'b0;
  logic [3:0] first_dly = 4'h1;
  logic [31:0] ADDR = 32'h0000_1240, VICTIM_ADDR = 32'h0000_8F60, co_a;
  logic [255:0] VICTIM_LINE = {{8{8'h04}}, {8{8'h03}}, {8{8'h02}}, {8{8'h01}}};
  logic [63:0] HIT_DATA = 64'hA5A5_0F0F_5A5A_F0F0, DATA_OUT;
  logic [255:0] co_line;
  logic address_ack_m, TRANSFER_ACK_IN, CACHE_BUS_GRANT, HIT_CLAIM, ADDRESS_ACK_OUT;
  logic ADDRESS_ACK_OE, ADDRESS_RETRY_OUT, ADDRESS_RETRY_OE, LINE_WT;
  logic TRANSFER_ACK_OUT, TRANSFER_ACK_OE, CACHE_BUS_REQUEST, DATA_OE;
  logic CO_TRANSFER_START, LINE_UPDATE, LINE_INVALIDATE, ARRAY_FILL;
  logic [31:0] CO_ADDR;
  wire ADDRESS_ACK_IN = address_ack_m | address_ack_tb;
  int failures = 0, checks_done = 0, ticks = 0, cyc, ta_at, ta_n, rq_at;
  int rq_last, co_at, rty_at, rty_last, mta_last, drv_n, upd_n, inv_n;
  int wt_n, fill_n;
  lcsb_top uut (.REF_CLK, .RESETN, .CE, .TRANSFER_START, .WRITE_THROUGH_ATTR,
    .IS_WRITE, .SNOOP, .ADDR, .LOOKUP_HIT, .LOOKUP_DIRTY, .VICTIM_ADDR,
    .VICTIM_LINE, .ADDRESS_ACK_IN, .TRANSFER_ACK_IN, .PROCESSOR_BUS_REQUEST,
    .PROCESSOR_DATA_GRANT, .CACHE_BUS_GRANT, .HIT_DATA, .HIT_CLAIM,
    .ADDRESS_ACK_OUT, .ADDRESS_ACK_OE, .ADDRESS_RETRY_OUT, .ADDRESS_RETRY_OE,
    .TRANSFER_ACK_OUT, .TRANSFER_ACK_OE, .CACHE_BUS_REQUEST,
    .CO_TRANSFER_START, .CO_ADDR, .DATA_OE, .DATA_OUT, .LINE_WT,
    .LINE_UPDATE, .LINE_INVALIDATE, .ARRAY_FILL);
  lcsb_mem_model mem (.clk(REF_CLK), .rst_n(RESETN), .mem_req(mreq),
    .co_ts(CO_TRANSFER_START), .first_dly(first_dly),
    .bus_req(CACHE_BUS_REQUEST), .gnt_en(gnt_en), .data_oe(DATA_OE),
    .data_in(DATA_OUT), .address_ack(address_ack_m), .ta(TRANSFER_ACK_IN),
    .gnt(CACHE_BUS_GRANT), .co_line(co_line));
  initial
  begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  task automatic test_done();
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cycle numbers count from the edge that takes the start strobe
  // Sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge REF_CLK)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      failures++;
      test_done();
    end
    else if (TRANSFER_START && RESETN)
    begin
      {cyc, ta_n, drv_n, upd_n, inv_n, wt_n, fill_n} = '0;
      {ta_at, rq_at, rq_last, co_at, rty_at, rty_last, mta_last} =
        {7{32'hFFFF_FFFF}};
    end
    else
    begin
      cyc++;
      ta_at = (TRANSFER_ACK_OUT && ta_n == 0) ? cyc : ta_at;
      ta_n += TRANSFER_ACK_OUT;
      rq_at = (CACHE_BUS_REQUEST && rq_at < 0) ? cyc : rq_at;
      rq_last = CACHE_BUS_REQUEST ? cyc : rq_last;
      rty_at = (ADDRESS_RETRY_OUT && rty_at < 0) ? cyc : rty_at;
      rty_last = ADDRESS_RETRY_OUT ? cyc : rty_last;
      mta_last = (TRANSFER_ACK_IN && co_at < 0) ? cyc : mta_last;
      if (CO_TRANSFER_START && co_at < 0)
      begin
        co_at = cyc;
        co_a = CO_ADDR;
      end
      drv_n += HIT_CLAIM | ADDRESS_ACK_OE | ADDRESS_RETRY_OE | DATA_OE
        | TRANSFER_ACK_OE | CACHE_BUS_REQUEST | CO_TRANSFER_START;
      upd_n += LINE_UPDATE;
      inv_n += LINE_INVALIDATE;
      wt_n += LINE_WT;
      fill_n += ARRAY_FILL;
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic issue(input logic s, w, wt, h, d, g);
    settle(1);
    {SNOOP, IS_WRITE, WRITE_THROUGH_ATTR} = {s, w, wt};
    {LOOKUP_HIT, LOOKUP_DIRTY, PROCESSOR_DATA_GRANT} = {h, d, g};
    mreq = !s && (!h || (w && wt));
    TRANSFER_START = 1'b1;
    settle(1);
    TRANSFER_START = 1'b0;
    mreq = 1'b0;
  endtask
  task automatic t_hit(input logic g);
    issue(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, g);
    PROCESSOR_DATA_GRANT = 1'b1;
    settle(12);
    PROCESSOR_DATA_GRANT = 1'b0;
    `CHK("first data ack", g ? 1 : 2, ta_at)
    `CHK("data ack count", 4, ta_n)
  endtask
  task automatic t_quiet();
    for (int i = 0; i < 3; i++)
    begin
      issue(1'b0, i != 1, i == 0, i == 0, 1'b0, 1'b1);
      settle(12);
      `CHK("bus drive", 0, drv_n)
      `CHK("write-through mark", i == 0, wt_n)
    end
  endtask
  task automatic t_miss(input logic [3:0] d);
    first_dly = d;
    issue(1'b0, d[1], 1'b0, 1'b0, 1'b1, 1'b1);
    settle(30);
    `CHK("miss request", 2, rq_at)
    `CHK("castout after miss", 1, co_at > mta_last && mta_last > 0)
    `CHK("castout line", VICTIM_LINE, co_line)
    `CHK("castout address", VICTIM_ADDR, co_a)
    `CHK("array fill", 1, fill_n)
  endtask
  task automatic t_snoop(input logic dfr, input logic w);
    issue(1'b1, w, 1'b0, 1'b1, 1'b1, 1'b0);
    settle(1);
    address_ack_tb = 1'b1;
    settle(1);
    {address_ack_tb, PROCESSOR_BUS_REQUEST} = {1'b0, !dfr};
    settle(1);
    PROCESSOR_BUS_REQUEST = dfr;
    settle(1);
    PROCESSOR_BUS_REQUEST = !dfr;
    settle(1);
    PROCESSOR_BUS_REQUEST = 1'b0;
    settle(20);
    `CHK("retry start", 1, rty_at)
    `CHK("request start", 1, rq_at)
    `CHK("retry end", 3, rty_last)
    `CHK("castout run", !dfr, co_at >= 5)
    `CHK("request dropped", 1, !dfr || rq_last <= 5)
    `CHK("line update", !w && dfr, upd_n)
    `CHK("line invalidate", w && dfr, inv_n)
    if (!dfr)
    begin
      `CHK("snoop castout address", ADDR, co_a)
      `CHK("snoop castout line", VICTIM_LINE, co_line)
    end
  endtask
  initial
  begin
    settle(5);
    RESETN = 1'b1;
    t_hit(1'b1);
    t_hit(1'b0);
    t_quiet();
    t_miss(4'h1);
    t_miss(4'h3);
    t_snoop(1'b0, 1'b0);
    t_snoop(1'b1, 1'b0);
    t_snoop(1'b1, 1'b1);
    test_done();
  end
endmodule
